// ===== dv/iem_asserts.sv
`timescale 1ns/1ps
module iem_asserts
  import iem_pkg::*;
(
  input wire logic       clock,
  input wire logic       rst_n,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic       sfr_write,
  input wire logic       sfr_read,
  input wire logic [7:0] sfr_rdata,
  input wire logic       sfr_hit,
  input wire logic [6:0] high_priority,
  input wire logic [6:0] irq_request,
  input wire logic       irq_any,
  input wire logic       irq_valid,
  input wire logic [2:0] irq_source,
  input wire logic       irq_high
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  logic [7:0] m;
  // shadow of the mask, so gating is judged from bus traffic only
  always_ff @(posedge clock)
    if (!rst_n) m <= IEM_REG_RESET;
    else if (sfr_write && sfr_addr == IEM_REG_ADDR) m <= sfr_wdata;
  a_gate_off: assert property (!m[7] |-> irq_request == 7'h00)
    else $error("request while gated");
  a_mask_only: assert property ((irq_request & ~m[6:0]) == 7'h00)
    else $error("masked request");
  a_any_or: assert property (irq_any == |irq_request)
    else $error("any mismatch");
  a_valid_next: assert property (1'b1 |=> irq_valid == $past(irq_any))
    else $error("valid mismatch");
  a_none_src: assert property (!irq_valid |-> irq_source == IEM_SRC_NONE)
    else $error("source without valid");
  a_ext0_first: assert property (irq_request[0] && high_priority == 7'h00
    |=> irq_source == IEM_SRC_EXT0) else $error("tie order");
  a_high_first: assert property (irq_request[6] && high_priority == 7'h40
    |=> irq_source == IEM_SRC_SPI && irq_high) else $error("high level lost");
  a_read_back: assert property (sfr_read && sfr_addr == IEM_REG_ADDR
    |=> sfr_hit && sfr_rdata == $past(m)) else $error("read data");
endmodule // iem_asserts
bind iem_interrupt_enable_mask iem_asserts u_chk (
  .clock         (clock),
  .rst_n         (rst_n),
  .sfr_addr      (sfr_addr),
  .sfr_wdata     (sfr_wdata),
  .sfr_write     (sfr_write),
  .sfr_read      (sfr_read),
  .sfr_rdata     (sfr_rdata),
  .sfr_hit       (sfr_hit),
  .high_priority (high_priority),
  .irq_request   (irq_request),
  .irq_any       (irq_any),
  .irq_valid     (irq_valid),
  .irq_source    (irq_source),
  .irq_high      (irq_high)
);

// ===== dv/iem_src_model.sv
`timescale 1ns/1ps
module iem_src_model
(
  input  wire logic [6:0] pend,
  input  wire logic [1:0] t2_mode,
  output logic      [7:0] src
);
  // t2_mode bit 0 lets the low flag follow pend[5], bit 1 the high flag; pins idle high
  assign src = {pend[6], pend[5] & t2_mode[0], pend[5] & t2_mode[1], pend[4], pend[3],
                ~pend[2], pend[1], ~pend[0]};
endmodule // iem_src_model

// ===== dv/iem_tb.sv
`timescale 1ns/1ps
module tb
  import iem_pkg::*;
;
  logic       clock = 0, rst_n = 0, sfr_write = 0, sfr_read = 0, sfr_hit, irq_any;
  logic       irq_valid, irq_high, rhit;
  logic [7:0] sfr_addr = 0, sfr_wdata = 0, sfr_rdata, src, rdat;
  logic [6:0] pend = 0, high_priority = 0, irq_request;
  logic [2:0] irq_source;
  logic [1:0] t2_mode = 2'h3;
  int         mismatches = 0, n_tests = 0;
  always #5 clock = ~clock;
  iem_src_model u_src (
    .pend    (pend),
    .t2_mode (t2_mode),
    .src     (src)
  );
  iem_interrupt_enable_mask dut (
    .clock                     (clock),
    .rst_n                     (rst_n),
    .sfr_addr                  (sfr_addr),
    .sfr_wdata                 (sfr_wdata),
    .sfr_write                 (sfr_write),
    .sfr_read                  (sfr_read),
    .sfr_rdata                 (sfr_rdata),
    .sfr_hit                   (sfr_hit),
    .spi_pending               (src[7]),
    .timer2_low_overflow_flag  (src[6]),
    .timer2_high_overflow_flag (src[5]),
    .uart_pending              (src[4]),
    .timer1_overflow_flag      (src[3]),
    .timer0_overflow_flag      (src[1]),
    .external_request1_pin     (src[2]),
    .external_request0_pin     (src[0]),
    .high_priority             (high_priority),
    .irq_request               (irq_request),
    .irq_any                   (irq_any),
    .irq_valid                 (irq_valid),
    .irq_source                (irq_source),
    .irq_high                  (irq_high)
  );
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      mismatches++;
    end
  endtask
  task automatic acc(input logic [7:0] a, input logic [7:0] d, input logic w);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_write = w;
    sfr_read = !w;
    cyc(1);
    rdat = sfr_rdata;
    rhit = sfr_hit;
    sfr_write = 0;
    sfr_read = 0;
    cyc(1);
  endtask
  task automatic t_gate_off;
    acc(IEM_REG_ADDR, 8'h00, 0);
    chk(rdat, IEM_REG_RESET);
    pend = 7'h7f;
    acc(IEM_REG_ADDR, 8'h7f, 1);
    cyc(2);
    chk({1'b0, irq_request}, 8'h00);
    chk({6'h00, irq_valid, irq_any}, 8'h00);
  endtask
  task automatic t_each_src;
    for (int i = 0; i < 7; i++)
    begin
      acc(IEM_REG_ADDR, 8'h80 | (8'h01 << i), 1);
      cyc(2);
      chk({1'b0, irq_request}, 8'h01 << i);
      chk({6'h00, irq_valid, irq_any}, 8'h03);
    end
  endtask
  task automatic t_timer2_split;
    t2_mode = 2'h1;
    acc(IEM_REG_ADDR, 8'ha0, 1);
    cyc(1);
    chk({1'b0, irq_request}, 8'h20);
    t2_mode = 2'h2;
    cyc(1);
    chk({1'b0, irq_request}, 8'h20);
    t2_mode = 2'h0;
    cyc(1);
    chk({1'b0, irq_request}, 8'h00);
    t2_mode = 2'h3;
  endtask
  task automatic t_pin_delay;
    pend = 7'h7e;
    acc(IEM_REG_ADDR, 8'h81, 1);
    cyc(1);
    chk({1'b0, irq_request}, 8'h00);
    pend = 7'h7f;
    cyc(1);
    chk({1'b0, irq_request}, 8'h00);
    cyc(1);
    chk({1'b0, irq_request}, 8'h01);
  endtask
  task automatic t_arbitrate;
    acc(IEM_REG_ADDR, 8'hff, 1);
    cyc(2);
    chk({5'h00, irq_source}, {5'h00, IEM_SRC_EXT0});
    high_priority = 7'h40;
    cyc(2);
    chk({4'h0, irq_high, irq_source}, {4'h0, 1'b1, IEM_SRC_SPI});
  endtask
  task automatic t_miss_addr;
    acc(8'ha9, 8'h00, 1);
    acc(8'ha9, 8'h00, 0);
    chk(rdat | {7'h00, rhit}, 8'h00);
    acc(IEM_REG_ADDR, 8'h00, 0);
    chk(rdat, 8'hff);
    chk({7'h00, rhit}, 8'h01);
  endtask
  task automatic t_reset_mid;
    rst_n = 0;
    cyc(2);
    rst_n = 1;
    chk({4'h0, irq_valid, irq_source}, {4'h0, 1'b0, IEM_SRC_NONE});
    acc(IEM_REG_ADDR, 8'h00, 0);
    chk(rdat, IEM_REG_RESET);
    chk({1'b0, irq_request}, 8'h00);
  endtask
  task automatic tally_and_finish;
    $display("mismatches %0d n_tests %0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    cyc(2);
    rst_n = 1;
    t_gate_off;
    t_each_src;
    t_timer2_split;
    t_pin_delay;
    t_arbitrate;
    t_miss_addr;
    t_reset_mid;
    tally_and_finish;
  end
  initial
  begin
    #20000;
    mismatches++;
    tally_and_finish;
  end
endmodule // tb

// ===== hw/iem_interrupt_enable_mask.sv
// Summary of operation
// - global gate clear blocks every source
// - global set: each source follows own enable
// - bit 6 gates serial peripheral requests
// - bit 5 gates timer2 low/high overflow
// - bit 4 gates uart request
// - bit 3 gates timer1 overflow
// - bit 2 gates active-low external input 1
// - bit 1 gates timer0 overflow
// - bit 0 gates active-low external input 0
// - requests sampled and decoded every cycle
// - equal-priority ties resolved by fixed order
`timescale 1ns/1ps
module iem_interrupt_enable_mask
  import iem_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic [7:0] sfr_addr,
  input  wire logic [7:0] sfr_wdata,
  input  wire logic       sfr_write,
  input  wire logic       sfr_read,
  output logic      [7:0] sfr_rdata,
  output logic            sfr_hit,
  input  wire logic       spi_pending,
  input  wire logic       timer2_low_overflow_flag,
  input  wire logic       timer2_high_overflow_flag,
  input  wire logic       uart_pending,
  input  wire logic       timer1_overflow_flag,
  input  wire logic       timer0_overflow_flag,
  input  wire logic       external_request1_pin,
  input  wire logic       external_request0_pin,
  input  wire logic [6:0] high_priority,
  output logic      [6:0] irq_request,
  output logic            irq_any,
  output logic            irq_valid,
  output logic      [2:0] irq_source,
  output logic            irq_high
);

  logic [7:0] interrupt_mask_register;
  logic [7:0] next_mask;
  logic       reg_sel;
  logic       write_hit;
  logic       read_hit;
  logic [1:0] ext_pin;
  logic [1:0] ext_active;
  logic [6:0] pending;
  logic [6:0] next_request;
  logic [6:0] prio_hi;
  logic [6:0] prio_lo;
  logic       global_irq_gate;
  logic [2:0] lo_source;
  logic       lo_found;
  logic [2:0] hi_source;
  logic       hi_found;
  logic [2:0] next_source;
  logic       next_valid;
  logic       next_high;

  assign global_irq_gate = interrupt_mask_register[IEM_BIT_GLOBAL];
  assign reg_sel         = sfr_addr == IEM_REG_ADDR;
  assign write_hit       = sfr_write & reg_sel;
  assign read_hit        = sfr_read & reg_sel;
  assign ext_pin         = {external_request1_pin, external_request0_pin};

  // bit-addressable writes arrive as byte writes from the core
  always_comb
  begin
    next_mask = interrupt_mask_register;
    if (write_hit)
      next_mask = sfr_wdata;
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
      interrupt_mask_register <= IEM_REG_RESET;
    else
      interrupt_mask_register <= next_mask;
  end

  // read path registered so data comes from flops
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      sfr_hit <= 1'b0;
    else
      sfr_hit <= read_hit;
  end

  // zero on a miss, so several responders can share one read bus
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      sfr_rdata <= 8'h00;
    else if (read_hit)
      sfr_rdata <= interrupt_mask_register;
    else
      sfr_rdata <= 8'h00;
  end

  // raw pin straight into the first flop; inverting later keeps logic off the async net
  genvar p;
  generate
    for (p = 0; p < 2; p++)
    begin : gen_sync
      logic sync_first;
      logic sync_second;
      // reset to the idle pin level, a low start would look like a request
      always_ff @(posedge clock)
      begin
        if (!rst_n)
        begin
          sync_first  <= IEM_SYNC_RESET[p];
          sync_second <= IEM_SYNC_RESET[p];
        end
        else
        begin
          sync_first  <= ext_pin[p];
          sync_second <= sync_first;
        end
      end
      assign ext_active[p] = ~sync_second;
    end
  endgenerate

  // pending vector in fixed order; bit index equals enable bit position
  always_comb
  begin
    pending                 = 7'h00;
    pending[IEM_BIT_EXT0]   = ext_active[0];
    pending[IEM_BIT_TIMER0] = timer0_overflow_flag;
    pending[IEM_BIT_EXT1]   = ext_active[1];
    pending[IEM_BIT_TIMER1] = timer1_overflow_flag;
    pending[IEM_BIT_UART]   = uart_pending;
    pending[IEM_BIT_TIMER2] = timer2_low_overflow_flag | timer2_high_overflow_flag;
    pending[IEM_BIT_SPI]    = spi_pending;
  end

  // per-source gating, combinational so a mask write acts next cycle
  genvar g;
  generate
    for (g = 0; g < IEM_NUM_SRC; g++)
    begin : gen_gate
      assign next_request[g] = pending[g] & interrupt_mask_register[g]
                               & global_irq_gate;
    end
  endgenerate

  assign irq_request = next_request;
  assign irq_any     = |next_request;
  assign prio_hi     = next_request & high_priority;
  assign prio_lo     = next_request & ~high_priority;

  // lowest index wins within a level; scanning downwards lets the last hit stand
  always_comb
  begin
    lo_source = IEM_SRC_NONE;
    lo_found  = 1'b0;
    for (int i = IEM_NUM_SRC - 1; i >= 0; i--)
    begin
      if (prio_lo[i])
      begin
        lo_source = 3'(i);
        lo_found  = 1'b1;
      end
    end
  end

  // same scan for the high level
  always_comb
  begin
    hi_source = IEM_SRC_NONE;
    hi_found  = 1'b0;
    for (int i = IEM_NUM_SRC - 1; i >= 0; i--)
    begin
      if (prio_hi[i])
      begin
        hi_source = 3'(i);
        hi_found  = 1'b1;
      end
    end
  end

  // a high-level request always beats a low-level one
  always_comb
  begin
    next_high  = hi_found;
    next_valid = hi_found | lo_found;
    if (hi_found)
      next_source = hi_source;
    else
      next_source = lo_source;
  end

  // decode result sampled every clock for the sequencer
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      irq_valid <= 1'b0;
    else
      irq_valid <= next_valid;
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
      irq_source <= IEM_SRC_NONE;
    else
      irq_source <= next_source;
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
      irq_high <= 1'b0;
    else
      irq_high <= next_high;
  end

endmodule // iem_interrupt_enable_mask

// ===== hw/iem_pkg.sv
package iem_pkg;
  // register map
  localparam logic [7:0] IEM_REG_ADDR        = 8'ha8;
  localparam logic [7:0] IEM_REG_RESET       = 8'h00;
  // field positions
  localparam int         IEM_BIT_GLOBAL      = 7;
  localparam int         IEM_BIT_SPI         = 6;
  localparam int         IEM_BIT_TIMER2      = 5;
  localparam int         IEM_BIT_UART        = 4;
  localparam int         IEM_BIT_TIMER1      = 3;
  localparam int         IEM_BIT_EXT1        = 2;
  localparam int         IEM_BIT_TIMER0      = 1;
  localparam int         IEM_BIT_EXT0        = 0;
  localparam int         IEM_NUM_SRC         = 7;
  // fixed arbitration order, index 0 wins
  localparam logic [2:0] IEM_SRC_EXT0        = 3'h0;
  localparam logic [2:0] IEM_SRC_TIMER0      = 3'h1;
  localparam logic [2:0] IEM_SRC_EXT1        = 3'h2;
  localparam logic [2:0] IEM_SRC_TIMER1      = 3'h3;
  localparam logic [2:0] IEM_SRC_UART        = 3'h4;
  localparam logic [2:0] IEM_SRC_TIMER2      = 3'h5;
  localparam logic [2:0] IEM_SRC_SPI         = 3'h6;
  localparam logic [2:0] IEM_SRC_NONE        = 3'h7;
  // synchroniser flops start at the idle pin level, so no false request after reset
  localparam logic [1:0] IEM_SYNC_RESET      = 2'h3;
endpackage
